// ### rtl/sid_pkg.sv
// Package for the compact instruction decoder and condition evaluator.
// Assumes a single core clock domain; shared by the decoder and the bench.
package sid_pkg;

  // ----------------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------------
  localparam int unsigned MAJ_HI     = 15;
  localparam int unsigned MAJ_LO     = 11;
  localparam int unsigned BREG_HI    = 10;
  localparam int unsigned BREG_LO    = 8;
  localparam int unsigned SUB3_HI    = 7;
  localparam int unsigned SUB3_LO    = 5;
  localparam int unsigned U5_HI      = 4;
  localparam int unsigned SUB2_HI    = 10;
  localparam int unsigned SUB2_LO    = 9;
  localparam int unsigned S9_HI      = 8;
  localparam int unsigned SUB1_BIT   = 7;
  localparam int unsigned S8_HI      = 7;
  localparam int unsigned U7_HI      = 6;
  localparam int unsigned CC3_HI     = 8;
  localparam int unsigned CC3_LO     = 6;
  localparam int unsigned S6_HI      = 5;
  localparam int unsigned S9B_HI     = 8;
  localparam int unsigned S11_HI     = 10;

  // ----------------------------------------------------------------------
  // Opcodes and sub-opcodes
  // ----------------------------------------------------------------------
  localparam logic [4:0] OP_SP       = 5'h18;
  localparam logic [4:0] OP_GP       = 5'h19;
  localparam logic [4:0] OP_PCREL    = 5'h1A;
  localparam logic [4:0] OP_MOVI     = 5'h1B;
  localparam logic [4:0] OP_ADDCMP   = 5'h1C;
  localparam logic [4:0] OP_BRZ      = 5'h1D;
  localparam logic [4:0] OP_BCC      = 5'h1E;
  localparam logic [4:0] OP_BLINK    = 5'h1F;
  localparam logic [2:0] SP_PUSH     = 3'h7;
  localparam logic [4:0] PUSH_REG    = 5'h01;
  localparam logic [4:0] PUSH_LINK   = 5'h11;
  localparam logic [1:0] GP_LDW      = 2'h0;
  localparam logic [1:0] GP_LDB      = 2'h1;
  localparam logic [1:0] GP_LDH      = 2'h2;
  localparam logic [1:0] GP_ADD      = 2'h3;
  localparam logic [1:0] BR_AL       = 2'h0;
  localparam logic [1:0] BR_EQ       = 2'h1;
  localparam logic [1:0] BR_NE       = 2'h2;
  localparam logic [1:0] BR_CC       = 2'h3;

  // ----------------------------------------------------------------------
  // Condition codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] CC_AL  = 5'h00;
  localparam logic [4:0] CC_EQ  = 5'h01;
  localparam logic [4:0] CC_NE  = 5'h02;
  localparam logic [4:0] CC_PL  = 5'h03;
  localparam logic [4:0] CC_MI  = 5'h04;
  localparam logic [4:0] CC_CS  = 5'h05;
  localparam logic [4:0] CC_CC  = 5'h06;
  localparam logic [4:0] CC_VS  = 5'h07;
  localparam logic [4:0] CC_VC  = 5'h08;
  localparam logic [4:0] CC_GT  = 5'h09;
  localparam logic [4:0] CC_GE  = 5'h0A;
  localparam logic [4:0] CC_LT  = 5'h0B;
  localparam logic [4:0] CC_LE  = 5'h0C;
  localparam logic [4:0] CC_HI  = 5'h0D;
  localparam logic [4:0] CC_LS  = 5'h0E;
  localparam logic [4:0] CC_PNZ = 5'h0F;
  localparam logic [4:0] CC_SS  = 5'h10;
  localparam logic [4:0] CC_SC  = 5'h11;
  localparam logic [2:0] CC3_BASE = 3'h0;

  // ----------------------------------------------------------------------
  // Sizes, registers and scaling
  // ----------------------------------------------------------------------
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam logic [5:0]  REG_R0     = 6'h00;
  localparam logic [5:0]  REG_LINK   = 6'h1F;
  localparam logic [31:0] PC_WMASK   = 32'hFFFF_FFFC;

  typedef enum logic [1:0] {SZ_WORD, SZ_BYTE, SZ_HALF} sid_size_t;
  typedef enum logic [2:0] {
    OPC_NONE, OPC_PUSH, OPC_LOAD, OPC_ADD, OPC_MOVE, OPC_CMP, OPC_BRANCH, OPC_BLINK
  } sid_op_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } sid_flags_t;

  typedef struct packed {
    logic [15:0] insn;
    logic [31:0] pc;
    logic        valid;
  } sid_fetch_t;

  typedef struct packed {
    logic        valid;
    sid_op_t     op;
    sid_size_t   size;
    logic [5:0]  dst_reg;
    logic        dst_we;
    logic [5:0]  src_reg;
    logic [31:0] imm;
    logic        set_flags;
    logic        insn_err;
    logic        is_cond_branch;
    logic [4:0]  cond;
    logic        reg_test_nz;
    logic        reg_test;
    logic [31:0] target;
    logic        sp_dec;
  } sid_decode_t;

endpackage

// ### rtl/sid_decoder.sv
// Compact 16-bit decoder for major opcodes 0x18 to 0x1F plus condition evaluation.
// Assumes fetch, execute and register file share clk_i; flags are presented here.
//
// How it works
// - Push register b: stack pointer minus four.
// - Push link register; b field ignored.
// - Other push sub-opcodes raise instruction error.
// - Global-pointer offset scaled by access size.
// - Global-pointer word, byte, half loads, add.
// - Load word from aligned PC plus offset.
// - Add or compare unsigned 7-bit immediate.
// - Compact ops leave flags unless compare type.
// - Branch when register zero or non-zero.
// - Branch always, equal, not equal, or subfield.
// - Subfield selects signed and unsigned compares.
// - Branch-and-link, 11 bits scaled to words.
// - Branch after flag setter stalls one cycle.
// - Short immediate forms run unconditionally.
// - Long forms set flags only with directive.
// - Compare and test never write registers.
// - Flags follow zero, sign, carry, overflow.
// - Code zero is always true; codes one to eight test single flags.
// - Signed codes combine N, V and Z.
// - Unsigned codes and positive non-zero.
// - Unimplemented extension codes: false or error.
// - Saturation set and clear codes.
`timescale 1ns/100ps

module sid_decoder #(
  parameter bit EXT_ARITH   = 1'b1,
  parameter bit EXT_CC_TRAP = 1'b0
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire sid_pkg::sid_fetch_t  fetch_i,
  input  wire sid_pkg::sid_flags_t  flags_i,
  input  wire logic [1:0]           sat_flags_i,
  input  wire logic [4:0]           cond_i,
  input  wire logic                 long_flag_cap_i,
  input  wire logic                 long_f_bit_i,
  input  wire logic                 long_cmp_i,
  input  wire logic [31:0]          result_i,
  input  wire logic                 carry_i,
  input  wire logic                 overflow_i,
  input  wire logic                 result_valid_i,
  input  wire logic                 reg_b_zero_i,
  output logic                      cond_true_o,
  output logic                      cond_err_o,
  output logic                      long_set_flags_o,
  output logic                      long_reg_we_o,
  output sid_pkg::sid_flags_t       flags_new_o,
  output logic                      flags_we_o,
  output logic                      stall_o,
  output logic                      branch_taken_o,
  output sid_pkg::sid_decode_t      dec_o
);

  // ----------------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------------
  function automatic logic [1:0] eval_cond(input logic [4:0] cc,
                                           input sid_pkg::sid_flags_t f,
                                           input logic [1:0] sat);
    logic t;
    logic e;
    t = 1'b0;
    e = 1'b0;
    case (cc)
      sid_pkg::CC_AL:  t = 1'b1;
      sid_pkg::CC_EQ:  t = f.z;
      sid_pkg::CC_NE:  t = ~f.z;
      sid_pkg::CC_PL:  t = ~f.n;
      sid_pkg::CC_MI:  t = f.n;
      sid_pkg::CC_CS:  t = f.c;
      sid_pkg::CC_CC:  t = ~f.c;
      sid_pkg::CC_VS:  t = f.v;
      sid_pkg::CC_VC:  t = ~f.v;
      sid_pkg::CC_GT:  t = (f.n == f.v) & ~f.z;
      sid_pkg::CC_GE:  t = (f.n == f.v);
      sid_pkg::CC_LT:  t = (f.n != f.v);
      sid_pkg::CC_LE:  t = f.z | (f.n != f.v);
      sid_pkg::CC_HI:  t = ~f.c & ~f.z;
      sid_pkg::CC_LS:  t = f.c | f.z;
      sid_pkg::CC_PNZ: t = ~f.n & ~f.z;
      sid_pkg::CC_SS: begin
        t = EXT_ARITH & (sat[0] | sat[1]);
        e = ~EXT_ARITH & EXT_CC_TRAP;
      end
      sid_pkg::CC_SC: begin
        t = EXT_ARITH & ~sat[0] & ~sat[1];
        e = ~EXT_ARITH & EXT_CC_TRAP;
      end
      default: begin
        t = 1'b0;
        e = EXT_CC_TRAP;
      end
    endcase
    return {e, t};
  endfunction

  logic [1:0] gen_res;
  always_comb begin
    gen_res          = eval_cond(cond_i, flags_i, sat_flags_i);
    cond_true_o      = gen_res[0];
    cond_err_o       = gen_res[1];
    long_set_flags_o = long_flag_cap_i & long_f_bit_i;
    long_reg_we_o    = ~long_cmp_i;
  end

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  sid_pkg::sid_decode_t dec_next;
  sid_pkg::sid_decode_t dec_reg;
  logic [15:0] ins;
  logic [4:0]  maj;
  logic [5:0]  breg;
  logic [31:0] pc_w;

  always_comb begin
    ins  = fetch_i.insn;
    maj  = ins[sid_pkg::MAJ_HI:sid_pkg::MAJ_LO];
    breg = {3'h0, ins[sid_pkg::BREG_HI:sid_pkg::BREG_LO]};
    pc_w = fetch_i.pc & sid_pkg::PC_WMASK;
    dec_next                = '0;
    dec_next.valid          = fetch_i.valid;
    dec_next.op             = sid_pkg::OPC_NONE;
    dec_next.size           = sid_pkg::SZ_WORD;
    dec_next.cond           = sid_pkg::CC_AL;
    case (maj)
      sid_pkg::OP_SP: begin
        if (ins[sid_pkg::SUB3_HI:sid_pkg::SUB3_LO] == sid_pkg::SP_PUSH) begin
          dec_next.op     = sid_pkg::OPC_PUSH;
          dec_next.sp_dec = 1'b1;
          dec_next.imm    = sid_pkg::STACK_STEP;
          case (ins[sid_pkg::U5_HI:0])
            sid_pkg::PUSH_REG:  dec_next.src_reg = breg;
            sid_pkg::PUSH_LINK: dec_next.src_reg = sid_pkg::REG_LINK;
            default: begin
              dec_next.op       = sid_pkg::OPC_NONE;
              dec_next.sp_dec   = 1'b0;
              dec_next.insn_err = 1'b1;
            end
          endcase
        end
      end
      sid_pkg::OP_GP: begin
        dec_next.dst_reg = sid_pkg::REG_R0;
        dec_next.dst_we  = 1'b1;
        dec_next.op      = sid_pkg::OPC_LOAD;
        case (ins[sid_pkg::SUB2_HI:sid_pkg::SUB2_LO])
          sid_pkg::GP_LDB: begin
            dec_next.size = sid_pkg::SZ_BYTE;
            dec_next.imm  = {{23{ins[sid_pkg::S9_HI]}}, ins[sid_pkg::S9_HI:0]};
          end
          sid_pkg::GP_LDH: begin
            dec_next.size = sid_pkg::SZ_HALF;
            dec_next.imm  = {{22{ins[sid_pkg::S9_HI]}}, ins[sid_pkg::S9_HI:0], 1'b0};
          end
          sid_pkg::GP_ADD: begin
            dec_next.op   = sid_pkg::OPC_ADD;
            dec_next.imm  = {{21{ins[sid_pkg::S9_HI]}}, ins[sid_pkg::S9_HI:0], 2'h0};
          end
          default: begin
            dec_next.imm  = {{21{ins[sid_pkg::S9_HI]}}, ins[sid_pkg::S9_HI:0], 2'h0};
          end
        endcase
      end
      sid_pkg::OP_PCREL: begin
        dec_next.op      = sid_pkg::OPC_LOAD;
        dec_next.dst_reg = breg;
        dec_next.dst_we  = 1'b1;
        dec_next.target  = pc_w + {22'h0, ins[7:0], 2'h0};
      end
      sid_pkg::OP_MOVI: begin
        dec_next.op      = sid_pkg::OPC_MOVE;
        dec_next.dst_reg = breg;
        dec_next.dst_we  = 1'b1;
        dec_next.imm     = {24'h0, ins[7:0]};
      end
      sid_pkg::OP_ADDCMP: begin
        dec_next.src_reg = breg;
        dec_next.imm     = {25'h0, ins[sid_pkg::U7_HI:0]};
        if (ins[sid_pkg::SUB1_BIT]) begin
          dec_next.op        = sid_pkg::OPC_CMP;
          dec_next.set_flags = 1'b1;
        end else begin
          dec_next.op      = sid_pkg::OPC_ADD;
          dec_next.dst_reg = breg;
          dec_next.dst_we  = 1'b1;
        end
      end
      sid_pkg::OP_BRZ: begin
        dec_next.op          = sid_pkg::OPC_BRANCH;
        dec_next.src_reg     = breg;
        dec_next.reg_test    = 1'b1;
        dec_next.reg_test_nz = ins[sid_pkg::SUB1_BIT];
        dec_next.target      = {fetch_i.pc[31:1] +
                                {{24{ins[sid_pkg::S6_HI + 1]}}, ins[sid_pkg::S6_HI + 1:0]}, 1'b0};
      end
      sid_pkg::OP_BCC: begin
        dec_next.op             = sid_pkg::OPC_BRANCH;
        dec_next.is_cond_branch = 1'b1;
        case (ins[sid_pkg::SUB2_HI:sid_pkg::SUB2_LO])
          sid_pkg::BR_AL: dec_next.cond = sid_pkg::CC_AL;
          sid_pkg::BR_EQ: dec_next.cond = sid_pkg::CC_EQ;
          sid_pkg::BR_NE: dec_next.cond = sid_pkg::CC_NE;
          default: begin
            case (ins[sid_pkg::CC3_HI:sid_pkg::CC3_LO])
              3'h0:    dec_next.cond = sid_pkg::CC_GT;
              3'h1:    dec_next.cond = sid_pkg::CC_GE;
              3'h2:    dec_next.cond = sid_pkg::CC_LT;
              3'h3:    dec_next.cond = sid_pkg::CC_LE;
              3'h4:    dec_next.cond = sid_pkg::CC_HI;
              3'h5:    dec_next.cond = sid_pkg::CC_CC;
              3'h6:    dec_next.cond = sid_pkg::CC_CS;
              default: dec_next.cond = sid_pkg::CC_LS;
            endcase
          end
        endcase
        if (ins[sid_pkg::SUB2_HI:sid_pkg::SUB2_LO] == sid_pkg::BR_CC) begin
          dec_next.target = {fetch_i.pc[31:1] +
                             {{25{ins[sid_pkg::S6_HI]}}, ins[sid_pkg::S6_HI:0]}, 1'b0};
        end else begin
          dec_next.target = {fetch_i.pc[31:1] +
                             {{22{ins[sid_pkg::S9B_HI]}}, ins[sid_pkg::S9B_HI:0]}, 1'b0};
        end
      end
      sid_pkg::OP_BLINK: begin
        dec_next.op      = sid_pkg::OPC_BLINK;
        dec_next.dst_reg = sid_pkg::REG_LINK;
        dec_next.dst_we  = 1'b1;
        dec_next.target  = pc_w + {{19{ins[sid_pkg::S11_HI]}}, ins[sid_pkg::S11_HI:0], 2'h0};
      end
      default: begin
        dec_next.valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Flag update and early-branch stall
  // ----------------------------------------------------------------------
  logic set_prev_reg;
  logic set_prev_next;
  logic is_br;
  logic [1:0] br_res;

  always_comb begin
    br_res        = eval_cond(dec_reg.cond, flags_i, sat_flags_i);
    flags_new_o.z = (result_i == 32'h0000_0000);
    flags_new_o.n = result_i[31];
    flags_new_o.c = carry_i;
    flags_new_o.v = overflow_i;
    flags_we_o    = result_valid_i & dec_reg.valid & dec_reg.set_flags;
    is_br         = dec_next.valid &
                    ((dec_next.op == sid_pkg::OPC_BRANCH) | (dec_next.op == sid_pkg::OPC_BLINK));
    stall_o       = is_br & set_prev_reg;
    set_prev_next = stall_o ? 1'b0 : (dec_next.valid & dec_next.set_flags);
    if (dec_reg.reg_test) begin
      branch_taken_o = dec_reg.valid & (reg_b_zero_i ^ dec_reg.reg_test_nz);
    end else if (dec_reg.op == sid_pkg::OPC_BRANCH) begin
      branch_taken_o = dec_reg.valid & br_res[0];
    end else begin
      branch_taken_o = dec_reg.valid & (dec_reg.op == sid_pkg::OPC_BLINK);
    end
    dec_o = dec_reg;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dec_reg      <= '0;
      set_prev_reg <= 1'b0;
    end else begin
      dec_reg      <= stall_o ? '0 : dec_next;
      set_prev_reg <= set_prev_next;
    end
  end

endmodule

// ### tb/sid_decoder_assertions.sv
// Concurrent checks on the compact decoder, seeing only its top-level ports.
// Assumes one clock domain, clk_i, and reset rst_i, asynchronous and active high.
`timescale 1ns/100ps
module sid_decoder_assertions (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire sid_pkg::sid_fetch_t  fetch_i,
  input wire sid_pkg::sid_flags_t  flags_i,
  input wire logic [4:0]           cond_i,
  input wire logic                 long_flag_cap_i,
  input wire logic                 long_f_bit_i,
  input wire logic [31:0]          result_i,
  input wire logic                 cond_true_o,
  input wire logic                 cond_err_o,
  input wire logic                 long_set_flags_o,
  input wire sid_pkg::sid_flags_t  flags_new_o,
  input wire logic                 stall_o,
  input wire sid_pkg::sid_decode_t dec_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------------
  logic        tk;
  logic        push_grp;
  logic [4:0]  maj;
  logic [31:0] bl_off;
  assign tk = fetch_i.valid && !stall_o;
  assign maj = fetch_i.insn[15:11];
  assign push_grp = tk && maj == sid_pkg::OP_SP && fetch_i.insn[7:5] == 3'h7;
  assign bl_off = {{19{fetch_i.insn[10]}}, fetch_i.insn[10:0], 2'h0};
  sequence s_bubble;
    stall_o ##1 !dec_o.valid;
  endsequence
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_PUSH_REG: assert property (push_grp && fetch_i.insn[4:0] == 5'h01 |=>
    dec_o.op == sid_pkg::OPC_PUSH && dec_o.sp_dec && !dec_o.insn_err &&
    dec_o.src_reg == {3'h0, $past(fetch_i.insn[10:8])}) else $error("push register wrong");
  AST_PUSH_LINK: assert property (push_grp && fetch_i.insn[4:0] == 5'h11 |=>
    dec_o.sp_dec && dec_o.src_reg == sid_pkg::REG_LINK) else $error("push link wrong");
  AST_PUSH_RSVD: assert property (push_grp && fetch_i.insn[4:0] != 5'h01 &&
    fetch_i.insn[4:0] != 5'h11 |=> dec_o.insn_err) else $error("reserved push accepted");
  AST_MOVE: assert property (tk && maj == sid_pkg::OP_MOVI |=> dec_o.dst_we &&
    !dec_o.set_flags && dec_o.imm == {24'h00_0000, $past(fetch_i.insn[7:0])})
    else $error("move immediate wrong");
  AST_CMP: assert property (tk && maj == sid_pkg::OP_ADDCMP && fetch_i.insn[7] |=>
    !dec_o.dst_we && dec_o.set_flags) else $error("compare wrote a register");
  AST_BLINK: assert property (tk && maj == sid_pkg::OP_BLINK |=> dec_o.target ==
    ($past(fetch_i.pc) & sid_pkg::PC_WMASK) + $past(bl_off)) else $error("link target wrong");
  AST_COND_GT: assert property (cond_i == sid_pkg::CC_GT |-> cond_true_o ==
    (flags_i.n == flags_i.v && !flags_i.z)) else $error("greater-than test wrong");
  AST_COND_PNZ: assert property (cond_i == sid_pkg::CC_PNZ |-> cond_true_o ==
    (!flags_i.n && !flags_i.z)) else $error("positive non-zero test wrong");
  AST_COND_RSVD: assert property (cond_i > 5'h11 |-> !cond_true_o && !cond_err_o)
    else $error("unimplemented code not false");
  AST_LONG_F: assert property (long_set_flags_o == (long_flag_cap_i && long_f_bit_i))
    else $error("long flag update wrong");
  AST_FLAGS: assert property (flags_new_o.z == (result_i == 32'h0000_0000) &&
    flags_new_o.n == result_i[31]) else $error("new flags wrong");
  AST_STALL: assert property (stall_o |-> s_bubble) else $error("stall without bubble");
endmodule

bind sid_decoder sid_decoder_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .fetch_i(fetch_i), .flags_i(flags_i), .cond_i(cond_i), .long_flag_cap_i(long_flag_cap_i),
  .long_f_bit_i(long_f_bit_i), .result_i(result_i), .cond_true_o(cond_true_o),
  .cond_err_o(cond_err_o), .long_set_flags_o(long_set_flags_o), .flags_new_o(flags_new_o),
  .stall_o(stall_o), .dec_o(dec_o));

// ### tb/sid_fetch_model.sv
// Fetch stage model presenting one compact instruction per rising clock edge.
// Assumes the bench sets the next instruction at the falling edge.
`timescale 1ns/100ps
module sid_fetch_model (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          stall_i,
  input  wire logic [15:0]   insn_i,
  input  wire logic [31:0]   pc_i,
  input  wire logic          valid_i,
  output sid_pkg::sid_fetch_t fetch_o
);
  // Holds a refused instruction until the decoder takes it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_o <= '0;
    end else if (!stall_i) begin
      fetch_o <= {insn_i, pc_i, valid_i};
    end
  end
endmodule

// ### tb/short_insn_decode_cond_eval_tb.sv
// Self-checking bench for the compact decoder and condition evaluator.
// Assumes the fetch model feeds fetch_i; every other input is driven here.
`timescale 1ns/100ps
module short_insn_decode_cond_eval_tb;
  logic clk_i, rst_i, long_flag_cap_i, long_f_bit_i, long_cmp_i, carry_i, overflow_i;
  logic result_valid_i, reg_b_zero_i, cond_true_o, cond_err_o, long_set_flags_o;
  logic long_reg_we_o, flags_we_o, stall_o, branch_taken_o, nx_valid;
  logic [1:0] sat_flags_i;
  logic [4:0] cond_i;
  logic [15:0] nx_insn;
  logic [31:0] result_i, nx_pc;
  sid_pkg::sid_fetch_t fetch_i;
  sid_pkg::sid_flags_t flags_i, flags_new_o;
  sid_pkg::sid_decode_t dec_o;
  int err_total, num_checks;

  sid_fetch_model u_fetch (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall_o), .insn_i(nx_insn),
    .pc_i(nx_pc), .valid_i(nx_valid), .fetch_o(fetch_i));
  sid_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .fetch_i(fetch_i), .flags_i(flags_i),
    .sat_flags_i(sat_flags_i), .cond_i(cond_i), .long_flag_cap_i(long_flag_cap_i),
    .long_f_bit_i(long_f_bit_i), .long_cmp_i(long_cmp_i), .result_i(result_i),
    .carry_i(carry_i), .overflow_i(overflow_i), .result_valid_i(result_valid_i),
    .reg_b_zero_i(reg_b_zero_i), .cond_true_o(cond_true_o), .cond_err_o(cond_err_o),
    .long_set_flags_o(long_set_flags_o), .long_reg_we_o(long_reg_we_o),
    .flags_new_o(flags_new_o), .flags_we_o(flags_we_o), .stall_o(stall_o),
    .branch_taken_o(branch_taken_o), .dec_o(dec_o));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic cc_exp(input logic [4:0] k, input sid_pkg::sid_flags_t f,
                                  input logic [1:0] s);
    logic [17:0] t;
    t = {~s[0] & ~s[1], |s, ~f.n & ~f.z, f.c | f.z, ~f.c & ~f.z,
         f.z | (f.n ^ f.v), f.n ^ f.v, f.n ~^ f.v, (f.n ~^ f.v) & ~f.z,
         ~f.v, f.v, ~f.c, f.c, f.n, ~f.n, ~f.z, f.z, 1'h1};
    return (k < 5'h12) ? t[k] : 1'h0;
  endfunction

  // Presents one instruction and waits until its decode stands on dec_o.
  task automatic run1(input logic [15:0] insn, input logic [31:0] pc);
    @(negedge clk_i);
    nx_insn = insn;
    nx_pc = pc;
    nx_valid = 1'h1;
    repeat (2) @(negedge clk_i);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_cond();
    for (int i = 0; i < 2048; i++) begin
      @(negedge clk_i);
      {cond_i, flags_i, sat_flags_i} = i[10:0];
      #1;
      chk("cond_true", cond_true_o, cc_exp(cond_i, flags_i, sat_flags_i));
      chk("cond_err", cond_err_o, 1'h0);
    end
  endtask

  task automatic t_long();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i);
      {long_flag_cap_i, long_f_bit_i, long_cmp_i} = i[2:0];
      #1;
      chk("long_set_flags", long_set_flags_o, long_flag_cap_i & long_f_bit_i);
      chk("long_reg_we", long_reg_we_o, !long_cmp_i);
    end
  endtask

  task automatic t_flags();
    logic [31:0] r [3] = '{32'h0000_0000, 32'h8000_0000, 32'h0000_0001};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_i);
      result_i = r[i];
      {carry_i, overflow_i} = i[1:0];
      #1;
      chk("flags_new", flags_new_o, {r[i][31], r[i] == 0, carry_i, overflow_i});
    end
  endtask

  task automatic t_push();
    for (int u = 0; u < 32; u++) begin
      run1({5'h18, 3'h5, 3'h7, u[4:0]}, 32'h0000_0100);
      chk("push_err", dec_o.insn_err, !(u == 1 || u == 17));
      if (u == 1) chk("push_src", {dec_o.sp_dec, dec_o.src_reg}, 7'h45);
      if (u == 17) chk("push_link", {dec_o.sp_dec, dec_o.src_reg}, 7'h5F);
    end
  endtask

  task automatic t_gp();
    logic [31:0] off;
    off = 32'hFFFF_FF81;
    for (int s = 0; s < 4; s++) begin
      run1({5'h19, s[1:0], 9'h181}, 32'h0000_0200);
      chk("gp_imm", dec_o.imm, off << ((s == 1) ? 0 : (s == 2) ? 1 : 2));
      chk("gp_dst", dec_o.dst_reg, sid_pkg::REG_R0);
      chk("gp_op", dec_o.op, (s == 3) ? sid_pkg::OPC_ADD : sid_pkg::OPC_LOAD);
      if (s == 0) chk("gp_size", dec_o.size, sid_pkg::SZ_WORD);
      if (s == 1) chk("gp_size", dec_o.size, sid_pkg::SZ_BYTE);
      if (s == 2) chk("gp_size", dec_o.size, sid_pkg::SZ_HALF);
    end
  endtask

  task automatic t_imm();
    result_valid_i = 1'h1;
    run1({5'h1A, 3'h2, 8'hC3}, 32'h0000_0302);
    chk("pcrel_op", dec_o.op, sid_pkg::OPC_LOAD);
    chk("pcrel_dst", dec_o.dst_reg, 6'h02);
    chk("pcrel_addr", dec_o.target, 32'h0000_060C);
    run1({5'h1B, 3'h6, 8'hF0}, 32'h0000_0304);
    chk("move", {dec_o.op, dec_o.dst_we, dec_o.set_flags}, {sid_pkg::OPC_MOVE, 2'h2});
    chk("move_imm", dec_o.imm, 32'h0000_00F0);
    chk("move_cond", dec_o.cond, sid_pkg::CC_AL);
    run1({5'h1C, 3'h1, 1'h1, 7'h7F}, 32'h0000_0306);
    chk("cmp", {dec_o.op, dec_o.dst_we, dec_o.set_flags}, {sid_pkg::OPC_CMP, 2'h1});
    chk("cmp_flags_we", flags_we_o, 1'h1);
    run1({5'h1C, 3'h1, 1'h0, 7'h7F}, 32'h0000_0308);
    chk("add", {dec_o.op, dec_o.dst_we, dec_o.set_flags}, {sid_pkg::OPC_ADD, 2'h2});
    chk("add_imm", dec_o.imm, 32'h0000_007F);
    chk("add_flags_we", flags_we_o, 1'h0);
  endtask

  task automatic t_branch();
    logic [4:0] map [8] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h06, 5'h05, 5'h0E};
    for (int i = 0; i < 4; i++) begin
      reg_b_zero_i = i[0];
      run1({5'h1D, 3'h4, i[1], 7'h10}, 32'h0000_0400);
      chk("brz_taken", branch_taken_o, i[1] ^ i[0]);
    end
    for (int i = 0; i < 6; i++) begin
      flags_i = {1'h0, i[0], 2'h0};
      run1({5'h1E, i[2:1], 9'h1F0}, 32'h0000_1003);
      chk("bcc_target", dec_o.target, 32'h0000_0FE2);
      chk("bcc_taken", branch_taken_o, (i < 2) | (i[2:1] == 1 ? i[0] : !i[0]));
    end
    for (int c = 0; c < 8; c++) begin
      run1({5'h1E, 2'h3, c[2:0], 6'h04}, 32'h0000_0500);
      for (int f = 0; f < 16; f++) begin
        @(negedge clk_i);
        flags_i = f[3:0];
        #1;
        chk("cc3_taken", branch_taken_o, cc_exp(map[c], flags_i, 2'h0));
      end
    end
    run1({5'h1F, 11'h401}, 32'h0000_2002);
    chk("bl_op", dec_o.op, sid_pkg::OPC_BLINK);
    chk("bl_target", dec_o.target, 32'h0000_1004);
  endtask

  task automatic t_stall();
    @(negedge clk_i);
    nx_insn = {5'h1C, 3'h1, 1'h1, 7'h01};
    @(negedge clk_i);
    nx_insn = {5'h1E, 2'h0, 9'h004};
    @(negedge clk_i);
    chk("stall", stall_o, 1'h1);
    @(negedge clk_i);
    chk("bubble", dec_o.valid, 1'h0);
    @(negedge clk_i);
    chk("retry", {dec_o.valid, dec_o.op}, {1'h1, sid_pkg::OPC_BRANCH});
  endtask

  // ----------------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    #200_000;
    err_total++;
    give_verdict();
  end

  initial begin
    {rst_i, err_total, num_checks} = '0;
    rst_i = 1'h1;
    {flags_i, sat_flags_i, cond_i, long_flag_cap_i, long_f_bit_i, long_cmp_i} = '0;
    {result_i, carry_i, overflow_i, result_valid_i, reg_b_zero_i} = '0;
    {nx_insn, nx_pc, nx_valid} = '0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'h0;
    t_cond();
    t_long();
    t_flags();
    t_push();
    t_gp();
    t_imm();
    t_branch();
    t_stall();
    give_verdict();
  end
endmodule
